// ===== verilog/bha_core.sv
// Processor bus handshake: cycle flags, acknowledge, read buffer, arbitration, dual pins
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// Operation
// - Drive read flag on reads and write flag on writes.
// - Write acknowledge moves to next narrow item or ends the write.
// - Read acknowledge lets the core consume the returned data.
// - Load enable captures the multiplexed bus data into the read buffer.
// - Output a reference clock that paces the bus state machine.
// - Bus request tristates the bus interface outputs.
// - Request negated returns the bus and the device drives again.
// - Grant output acknowledges request and released bus.
// - With DMA protocol on, drop grant early and wait for request negation.
// - Branch mode routes condition pin 3 to coprocessor condition 3.
// - Condition inputs are synchronised before use.
// - Strobe mode drives pin 3 in second cycle of configured transfers.
// - Branch mode routes condition pin 2 to coprocessor condition 2.
// - Pin 2 selects branch input or extended data enable by control.
// - Extended data enable asserts as configured, holds half cycle after flags.
module bha_core (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_req,
    input wire logic core_write,
    input wire logic [31:0] core_addr,
    input wire logic [31:0] core_wdata,
    input wire logic [bha_pkg::BHA_ITEM_BITS-1:0] core_items,
    output logic core_done,
    output logic [31:0] core_rdata,
    output logic [31:0] ad_out,
    output logic ad_oe,
    input wire logic [31:0] ad_in,
    output logic [31:0] addr_out,
    output logic read_cycle_n,
    output logic write_cycle_n,
    output logic bus_ctl_oe,
    input wire logic ack_n,
    input wire logic read_buffer_load_enable_n,
    output logic system_reference_clock,
    input wire logic bus_request_in_n,
    output logic bus_grant_out_n,
    input wire logic branch_condition_pin_3_in,
    output logic branch_condition_pin_3_out,
    output logic branch_condition_pin_3_oe,
    input wire logic branch_condition_pin_2_in,
    output logic branch_condition_pin_2_out,
    output logic branch_condition_pin_2_oe,
    output logic coproc_condition_3,
    output logic coproc_condition_2
);
    import bha_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bha_state_e state;
        logic ref_clk;
        logic is_write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [BHA_ITEM_BITS-1:0] items;
        logic [1:0] cyc;
        logic [31:0] rdbuf;
        logic [31:0] rdata;
        logic done;
        logic rd_n;
        logic wr_n;
        logic drive_ad;
        logic grant_n;
        logic strobe;
        logic ext;
    } bha_core_s;

    bha_core_s st_q;
    bha_core_s st_d;

    logic [BHA_CTRL_BITS-1:0] ctrl;
    logic [BHA_STAT_BITS-1:0] status;
    logic [BHA_SYNC_WIDTH-1:0] pins_raw;
    logic [BHA_SYNC_WIDTH-1:0] pins_sync;
    logic ack_s;
    logic rdce_s;
    logic req_s;
    logic cond2_s;
    logic cond3_s;
    logic tick;
    logic ext_now;
    logic bus_owned;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    bha_regs u_regs (
        .mclk(mclk),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .ctrl(ctrl)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Handshake pins are synchronised as well since the memory system may
    // run from its own copy of the reference clock with unknown skew.
    assign pins_raw = {branch_condition_pin_3_in, branch_condition_pin_2_in,
                       ~bus_request_in_n, ~read_buffer_load_enable_n, ~ack_n};

    bha_sync #(
        .WIDTH(BHA_SYNC_WIDTH)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign ack_s = pins_sync[0];
    assign rdce_s = pins_sync[1];
    assign req_s = pins_sync[2];
    assign cond2_s = pins_sync[3];
    assign cond3_s = pins_sync[4];

    // ------------------------------------------------------------------
    // Reference clock and bus tick
    // ------------------------------------------------------------------
    // The bus machine moves only on the edge where the reference clock rises
    assign tick = !st_q.ref_clk;

    // Extended data enable source: flags active for the configured direction
    assign ext_now = (!st_q.rd_n && ctrl[BHA_C_EXT_RD])
                   || (!st_q.wr_n && ctrl[BHA_C_EXT_WR]);

    assign bus_owned = (st_q.state != BHA_GRANTED) && (st_q.state != BHA_RECLAIM);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.ref_clk = !st_q.ref_clk;
        st_d.done = 1'b0;
        // Read buffer loads whenever the enable is seen in the data state of a read
        if (rdce_s && st_q.state == BHA_DATA && !st_q.is_write)
            st_d.rdbuf = ad_in;
        if (tick)
        begin
            case (st_q.state)
                BHA_IDLE:
                begin
                    // Bus request takes priority over a pending core transfer
                    if (req_s)
                    begin
                        st_d.state = BHA_GRANTED;
                        st_d.grant_n = 1'b0;
                    end
                    else if (core_req)
                    begin
                        st_d.state = BHA_ADDR;
                        st_d.is_write = core_write;
                        st_d.addr = core_addr;
                        st_d.wdata = core_wdata;
                        st_d.items = core_items;
                        st_d.cyc = 2'h0;
                        st_d.rd_n = core_write;
                        st_d.wr_n = !core_write;
                        st_d.drive_ad = 1'b1;
                    end
                end
                BHA_ADDR:
                begin
                    st_d.state = BHA_DATA;
                    st_d.cyc = BHA_IO_STROBE_CYCLE;
                    st_d.drive_ad = st_q.is_write;
                    st_d.strobe = st_q.is_write ? ctrl[BHA_C_STB_WR]
                                                : ctrl[BHA_C_STB_RD];
                end
                BHA_DATA:
                begin
                    st_d.strobe = 1'b0;
                    if (st_q.cyc != 2'h3)
                        st_d.cyc = st_q.cyc + 2'h1;
                    if (ack_s && st_q.is_write && st_q.items != '0)
                    begin
                        // Next narrow item: advance address, shift data down
                        st_d.items = st_q.items - 1'b1;
                        st_d.addr = st_q.addr + 32'h0000_0001;
                        st_d.wdata = {8'h00, st_q.wdata[31:8]};
                    end
                    else if (ack_s)
                    begin
                        st_d.state = BHA_IDLE;
                        st_d.rd_n = 1'b1;
                        st_d.wr_n = 1'b1;
                        st_d.drive_ad = 1'b0;
                        st_d.done = 1'b1;
                        st_d.rdata = st_q.is_write ? st_q.rdata
                                   : (rdce_s ? ad_in : st_q.rdbuf);
                    end
                end
                BHA_GRANTED:
                begin
                    if (!req_s)
                    begin
                        st_d.state = BHA_IDLE;
                        st_d.grant_n = 1'b1;
                    end
                    else if (ctrl[BHA_C_DMA_PROTO] && core_req)
                    begin
                        // Ask for the bus back, master keeps it until it lets go
                        st_d.state = BHA_RECLAIM;
                        st_d.grant_n = 1'b1;
                    end
                end
                BHA_RECLAIM:
                begin
                    if (!req_s)
                        st_d.state = BHA_IDLE;
                end
                default:
                begin
                    st_d.state = BHA_IDLE;
                    st_d.grant_n = 1'b1;
                end
            endcase
        end
        // Built from the next flags so the pin has no lag; one mclk is half a reference cycle
        st_d.ext = (!st_d.rd_n && ctrl[BHA_C_EXT_RD]) || (!st_d.wr_n && ctrl[BHA_C_EXT_WR])
                 || ext_now;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q.state <= BHA_IDLE;
            st_q.ref_clk <= 1'b0;
            st_q.is_write <= 1'b0;
            st_q.addr <= '0;
            st_q.wdata <= '0;
            st_q.items <= '0;
            st_q.cyc <= 2'h0;
            st_q.rdbuf <= '0;
            st_q.rdata <= '0;
            st_q.done <= 1'b0;
            st_q.rd_n <= 1'b1;
            st_q.wr_n <= 1'b1;
            st_q.drive_ad <= 1'b0;
            st_q.grant_n <= 1'b1;
            st_q.strobe <= 1'b0;
            st_q.ext <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign system_reference_clock = st_q.ref_clk;
    assign bus_grant_out_n = st_q.grant_n;
    assign bus_ctl_oe = bus_owned;
    assign ad_oe = bus_owned && st_q.drive_ad;
    assign ad_out = (st_q.state == BHA_ADDR) ? st_q.addr : st_q.wdata;
    assign addr_out = st_q.addr;
    assign read_cycle_n = st_q.rd_n;
    assign write_cycle_n = st_q.wr_n;
    assign core_done = st_q.done;
    assign core_rdata = st_q.rdata;

    // Pin 3: branch input or I/O strobe
    assign branch_condition_pin_3_oe = ctrl[BHA_C_PIN3_STROBE];
    assign branch_condition_pin_3_out = st_q.strobe;
    assign coproc_condition_3 = !ctrl[BHA_C_PIN3_STROBE] && cond3_s;

    // Pin 2: branch input or extended data enable
    assign branch_condition_pin_2_oe = ctrl[BHA_C_PIN2_EXTDATA];
    assign branch_condition_pin_2_out = st_q.ext;
    assign coproc_condition_2 = !ctrl[BHA_C_PIN2_EXTDATA] && cond2_s;

    assign status = {req_s, cond3_s, cond2_s,
                     (st_q.state == BHA_ADDR) || (st_q.state == BHA_DATA),
                     st_q.state == BHA_RECLAIM, !st_q.grant_n};
endmodule

// ===== verilog/bha_pkg.sv
// Shared constants and types of the bus handshake and arbitration block
package bha_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] BHA_CTRL_ADDR = 12'h000;
    localparam logic [11:0] BHA_STAT_ADDR = 12'h004;
    localparam logic [31:0] BHA_CTRL_RESET = 32'h0000_0000;
    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int BHA_C_DMA_PROTO = 0;
    localparam int BHA_C_PIN3_STROBE = 1;
    localparam int BHA_C_PIN2_EXTDATA = 2;
    localparam int BHA_C_STB_RD = 3;
    localparam int BHA_C_STB_WR = 4;
    localparam int BHA_C_EXT_RD = 5;
    localparam int BHA_C_EXT_WR = 6;
    localparam int BHA_CTRL_BITS = 7;
    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int BHA_S_GRANTED = 0;
    localparam int BHA_S_RECLAIM = 1;
    localparam int BHA_S_BUSY = 2;
    localparam int BHA_S_COND2 = 3;
    localparam int BHA_S_COND3 = 4;
    localparam int BHA_S_REQ = 5;
    localparam int BHA_STAT_BITS = 6;
    // ------------------------------------------------------------------
    // Timing and widths
    // ------------------------------------------------------------------
    localparam int BHA_SYNC_WIDTH = 5;
    localparam int BHA_ITEM_BITS = 2;
    localparam logic [1:0] BHA_IO_STROBE_CYCLE = 2'h1;
    localparam logic [31:0] BHA_APB_ERR_DATA = 32'h0000_0000;
    typedef enum {
        BHA_IDLE,
        BHA_ADDR,
        BHA_DATA,
        BHA_GRANTED,
        BHA_RECLAIM
    } bha_state_e;
endpackage

// ===== verilog/bha_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module bha_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bha_sync_s;

    bha_sync_s st_q;
    bha_sync_s st_d;

    // First stage feeds only the second stage
    always_comb
    begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_out = st_q.stable;
endmodule

// ===== verilog/bha_regs.sv
// APB register file: control settings and block status
`timescale 1ns/1ns
module bha_regs (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [bha_pkg::BHA_STAT_BITS-1:0] status,
    output logic [bha_pkg::BHA_CTRL_BITS-1:0] ctrl
);
    import bha_pkg::*;

    typedef struct packed {
        logic [BHA_CTRL_BITS-1:0] ctrl;
        logic [31:0] rdata;
        logic err;
    } bha_regs_s;

    bha_regs_s st_q;
    bha_regs_s st_d;
    logic hit_ctrl;
    logic hit_stat;

    assign hit_ctrl = (paddr == BHA_CTRL_ADDR);
    assign hit_stat = (paddr == BHA_STAT_ADDR);

    always_comb
    begin
        st_d = st_q;
        // Read data and error are prepared in the setup cycle
        if (psel && !penable)
        begin
            st_d.err = !(hit_ctrl || hit_stat);
            st_d.rdata = BHA_APB_ERR_DATA;
            if (!pwrite && hit_ctrl)
                st_d.rdata = {{(32-BHA_CTRL_BITS){1'b0}}, st_q.ctrl};
            else if (!pwrite && hit_stat)
                st_d.rdata = {{(32-BHA_STAT_BITS){1'b0}}, status};
        end
        // Write takes effect at the access edge only
        if (psel && penable && pwrite && hit_ctrl)
            st_d.ctrl = pwdata[BHA_CTRL_BITS-1:0];
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q.ctrl <= BHA_CTRL_RESET[BHA_CTRL_BITS-1:0];
            st_q.rdata <= '0;
            st_q.err <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & st_q.err;
    assign prdata = st_q.rdata;
    assign ctrl = st_q.ctrl;
endmodule

// ===== tb/bha_mem_model.sv
// Memory controller and external bus master model for the handshake block
`timescale 1ns/1ns
module bha_mem_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic read_cycle_n,
    input wire logic write_cycle_n,
    input wire logic bus_grant_out_n,
    input wire logic [31:0] rd_word,
    input wire logic [3:0] delay,
    input wire logic dma_want,
    output logic [31:0] ad_in,
    output logic ack_n,
    output logic read_buffer_load_enable_n,
    output logic bus_request_in_n
);
    logic [3:0] cnt_q;
    logic gnt_q;
    logic drop_q;
    logic hold_q;
    logic cyc;
    logic win;
    assign cyc = !read_cycle_n || !write_cycle_n;
    assign win = cyc && cnt_q >= delay && cnt_q < delay + 4'h2;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= 4'h0;
            ad_in <= 32'h0;
            ack_n <= 1'h1;
            read_buffer_load_enable_n <= 1'h1;
            bus_request_in_n <= 1'h1;
            gnt_q <= 1'h0;
            drop_q <= 1'h0;
            hold_q <= 1'h0;
        end
        else
        begin
            // Two-cycle acknowledge, so one pulse moves exactly one item
            cnt_q <= (cyc && cnt_q != delay + 4'h2) ? cnt_q + 4'h1 : 4'h0;
            ack_n <= !win;
            read_buffer_load_enable_n <= !(win && !read_cycle_n);
            hold_q <= !read_cycle_n && (hold_q || win);
            // Data valid only once loaded; otherwise the bus shows no stale word
            ad_in <= (!read_cycle_n && (hold_q || win)) ? rd_word : ~ad_in;
            if (!bus_grant_out_n)
                gnt_q <= 1'h1;
            if (!dma_want)
                drop_q <= 1'h0;
            else if (gnt_q && bus_grant_out_n && !bus_request_in_n)
                drop_q <= 1'h1;
            if (!dma_want || drop_q || (gnt_q && bus_grant_out_n))
            begin
                bus_request_in_n <= 1'h1;
                gnt_q <= 1'h0;
            end
            else
                bus_request_in_n <= 1'h0;
        end
    end
endmodule

// ===== tb/bha_core_chk.sv
// Concurrent checks on the ports of the bus handshake block
`timescale 1ns/1ns
module bha_core_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ad_oe,
    input wire logic read_cycle_n,
    input wire logic write_cycle_n,
    input wire logic bus_ctl_oe,
    input wire logic ack_n,
    input wire logic system_reference_clock,
    input wire logic bus_request_in_n,
    input wire logic bus_grant_out_n,
    input wire logic branch_condition_pin_3_in,
    input wire logic branch_condition_pin_3_out,
    input wire logic branch_condition_pin_3_oe,
    input wire logic branch_condition_pin_2_in,
    input wire logic branch_condition_pin_2_out,
    input wire logic branch_condition_pin_2_oe,
    input wire logic coproc_condition_3,
    input wire logic coproc_condition_2
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic idle;
    assign idle = read_cycle_n & write_cycle_n;
    chk_flags_excl: assert property (read_cycle_n || write_cycle_n)
        else $error("read and write flags low together");
    chk_ack_cause: assert property ($rose(idle) |->
        !$past(ack_n, 3) || !$past(ack_n, 4) || !$past(ack_n, 5))
        else $error("cycle ended without acknowledge");
    chk_ref_toggle: assert property ($past(resetn) |->
        system_reference_clock != $past(system_reference_clock))
        else $error("reference clock did not toggle");
    chk_grant_cause: assert property ($fell(bus_grant_out_n) |->
        !$past(bus_request_in_n, 3) && $past(idle))
        else $error("grant without request or during a cycle");
    chk_grant_tristate: assert property (!bus_grant_out_n |-> !bus_ctl_oe && !ad_oe)
        else $error("bus driven while granted");
    chk_reclaim_wait: assert property (!bus_ctl_oe && !bus_request_in_n |=> !bus_ctl_oe)
        else $error("bus reclaimed while request asserted");
    chk_strobe_cycle: assert property ($rose(branch_condition_pin_3_out) |->
        !$past(idle, 2) && $past(idle, 4))
        else $error("io strobe not in second cycle");
    chk_ext_hold: assert property ($rose(idle) && $past(branch_condition_pin_2_out) |->
        branch_condition_pin_2_out ##1 !branch_condition_pin_2_out)
        else $error("extended enable hold wrong");
    chk_cond3_route: assert property (($stable(branch_condition_pin_3_in) &&
        !branch_condition_pin_3_oe)[*4] |-> coproc_condition_3 == branch_condition_pin_3_in)
        else $error("condition 3 not routed");
    chk_cond2_route: assert property (($stable(branch_condition_pin_2_in) &&
        !branch_condition_pin_2_oe)[*4] |-> coproc_condition_2 == branch_condition_pin_2_in)
        else $error("condition 2 not routed");
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the bus handshake and arbitration block
`timescale 1ns/1ns
module testbench;
    import bha_pkg::*;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, core_addr, core_wdata, core_rdata, ad_out, ad_in, addr_out;
    logic [31:0] rd_word, last_ad, rv;
    logic core_req, core_write, core_done, ad_oe, read_cycle_n, write_cycle_n, bus_ctl_oe, ack_n;
    logic read_buffer_load_enable_n, system_reference_clock, bus_request_in_n, bus_grant_out_n;
    logic branch_condition_pin_3_in, branch_condition_pin_3_out, branch_condition_pin_3_oe;
    logic branch_condition_pin_2_in, branch_condition_pin_2_out, branch_condition_pin_2_oe;
    logic coproc_condition_3, coproc_condition_2, dma_want, p3_drv, p2_drv;
    logic [BHA_ITEM_BITS-1:0] core_items;
    logic [3:0] delay, seen;
    int n_mismatch, samples_checked, acks;
    bha_core u_bha_core (.*);
    bha_mem_model u_bha_mem_model (.mclk(mclk), .resetn(resetn), .read_cycle_n(read_cycle_n),
        .write_cycle_n(write_cycle_n), .bus_grant_out_n(bus_grant_out_n), .rd_word(rd_word),
        .delay(delay), .dma_want(dma_want), .ad_in(ad_in), .ack_n(ack_n),
        .read_buffer_load_enable_n(read_buffer_load_enable_n),
        .bus_request_in_n(bus_request_in_n));
    // Pin level resolved from the device enable, bench drives otherwise
    assign branch_condition_pin_3_in = branch_condition_pin_3_oe ?
        branch_condition_pin_3_out : p3_drv;
    assign branch_condition_pin_2_in = branch_condition_pin_2_oe ?
        branch_condition_pin_2_out : p2_drv;
    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'h1);
        rv = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic xfer(input logic w, input logic [31:0] d, input logic [1:0] it,
        input logic [3:0] dl);
        logic pa;
        pa = 1'h1;
        seen = 4'h0;
        acks = 0;
        @(posedge mclk);
        delay <= dl;
        rd_word <= d;
        core_write <= w;
        core_addr <= 32'h0000_0100;
        core_wdata <= d;
        core_items <= it;
        core_req <= 1'h1;
        do
        begin
            @(negedge mclk);
            seen = seen | {!read_cycle_n, !write_cycle_n,
                branch_condition_pin_3_out & branch_condition_pin_3_oe,
                branch_condition_pin_2_out & branch_condition_pin_2_oe};
            if (pa && !ack_n)
            begin
                acks++;
                last_ad = ad_out;
            end
            pa = ack_n;
        end
        while (core_done !== 1'h1);
        @(posedge mclk);
        core_req <= 1'h0;
    endtask
    task automatic wait_gnt(input logic v);
        do
        begin
            @(negedge mclk);
        end
        while (bus_grant_out_n !== v);
    endtask
    task automatic t_regs();
        apb(1'h0, BHA_CTRL_ADDR, 32'h0);
        check("ctrl reset", BHA_CTRL_RESET, rv);
        apb(1'h1, BHA_CTRL_ADDR, 32'hffff_ffff);
        apb(1'h0, BHA_CTRL_ADDR, 32'h0);
        check("ctrl rw", 32'h0000_007f, rv);
        apb(1'h1, 12'h008, 32'h0000_0001);
        check("unmapped err", 32'h1, err);
        apb(1'h0, 12'h008, 32'h0);
        check("unmapped data", BHA_APB_ERR_DATA, rv);
        apb(1'h1, BHA_CTRL_ADDR, 32'h0);
    endtask
    task automatic t_xfer();
        xfer(1'h0, 32'ha5c3_0f96, 2'h0, 4'h3);
        check("read data", 32'ha5c3_0f96, core_rdata);
        check("read flags", 32'h8, seen & 4'hc);
        xfer(1'h0, 32'h5a3c_f069, 2'h0, 4'h9);
        check("slow read data", 32'h5a3c_f069, core_rdata);
        xfer(1'h1, 32'h1122_3344, 2'h3, 4'h3);
        check("write acks", 32'h4, acks);
        check("write flags", 32'h4, seen & 4'hc);
        check("last item", 32'h0000_0011, last_ad);
        check("last addr", 32'h0000_0103, addr_out);
    endtask
    task automatic t_pins();
        logic [3:0] cfg;
        for (int c = 0; c < 2; c++)
            for (int w = 0; w < 2; w++)
            begin
                // Each setting enables one direction only, so both outcomes show
                cfg = c ? 4'ha : 4'h5;
                apb(1'h1, BHA_CTRL_ADDR, {25'h0, cfg, 3'h6});
                xfer(w[0], 32'h0f0f_f0f0, 2'h0, 4'h3);
                check("io strobe", cfg[w], seen[1]);
                check("ext enable", cfg[2 + w], seen[0]);
            end
    endtask
    task automatic t_cond();
        for (int v = 0; v < 4; v++)
        begin
            apb(1'h1, BHA_CTRL_ADDR, 32'h0);
            p3_drv <= v[1];
            p2_drv <= v[0];
            repeat (4) @(posedge mclk);
            check("cond3", v[1], coproc_condition_3);
            check("cond2", v[0], coproc_condition_2);
        end
        apb(1'h1, BHA_CTRL_ADDR, 32'h4);
        // Synchronised level is still high here, so only the mode gate clears it
        @(negedge mclk);
        check("cond2 ext mode", 32'h0, coproc_condition_2);
    endtask
    task automatic t_dma();
        apb(1'h1, BHA_CTRL_ADDR, 32'h0);
        dma_want <= 1'h1;
        wait_gnt(1'h0);
        check("granted oe", 32'h0, {bus_ctl_oe, ad_oe});
        apb(1'h0, BHA_STAT_ADDR, 32'h0);
        check("granted status", 32'h1, rv[BHA_S_GRANTED]);
        dma_want <= 1'h0;
        wait_gnt(1'h1);
        check("owned oe", 32'h1, bus_ctl_oe);
        apb(1'h1, BHA_CTRL_ADDR, 32'h1);
        dma_want <= 1'h1;
        wait_gnt(1'h0);
        xfer(1'h0, 32'hc001_d00d, 2'h0, 4'h3);
        check("reclaim read", 32'hc001_d00d, core_rdata);
        dma_want <= 1'h0;
    endtask
    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        {resetn, psel, penable, pwrite, core_req, core_write, dma_want, p3_drv, p2_drv} = 9'h0;
        {paddr, pwdata, core_addr, core_wdata, rd_word} = 140'h0;
        core_items = 2'h0;
        delay = 4'h3;
        repeat (20) @(posedge mclk);
        resetn <= 1'h1;
        t_regs();
        t_xfer();
        t_pins();
        t_cond();
        t_dma();
        end_sim();
    end
    // Whole run takes a few hundred cycles; this limit only cuts a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_sim();
    end
endmodule
bind bha_core bha_core_chk u_bha_core_chk (.*);
